// [core/ars_pkg.sv]
// package: constants, types and address map of the auto-reclose sequencer
package ars_pkg;

    // ------------------------------------------------------------
    // clock and timer steps
    // ------------------------------------------------------------
    localparam int CLK_HZ          = 25_000_000;
    localparam int FINE_STEP_US    = 500;
    localparam int FINE_CYC        = CLK_HZ / 1_000_000 * FINE_STEP_US;
    localparam int COARSE_STEP_US  = 5000;
    localparam int FINE_PER_COARSE = COARSE_STEP_US / FINE_STEP_US;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NCH    = 5;
    localparam int NSHOT  = 5;
    localparam int NOBJ   = 5;
    localparam int NGRP   = 2;
    localparam int TW     = 22;
    localparam int AW     = 13;
    localparam int MEM_AW = 10;

    // ------------------------------------------------------------
    // address map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [AW-1:0] A_CTRL   = 13'h0000;
    localparam logic [AW-1:0] A_STAT   = 13'h0004;
    localparam logic [AW-1:0] A_GEN0   = 13'h0100;
    localparam logic [AW-1:0] A_LOCK0  = 13'h0104;
    localparam logic [AW-1:0] A_OBJT0  = 13'h0108;
    localparam logic [AW-1:0] GRP_STEP = 13'h0010;
    localparam int            SHOT_SEL_BIT = 12;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_MASTER   = 0;
    localparam int CTRL_USE_ONOFF = 1;
    localparam int GEN_EN        = 0;
    localparam int GEN_OBJ_LO    = 1;
    localparam int GEN_CLOSE_RST = 4;
    localparam int GEN_GEN_RECL  = 5;
    localparam int SC_EN         = 0;
    localparam int SC_DISCR      = 1;
    localparam logic [2:0] F_CFG   = 3'h0;
    localparam logic [2:0] F_START = 3'h1;
    localparam logic [2:0] F_DEAD  = 3'h2;
    localparam logic [2:0] F_ACT   = 3'h3;
    localparam logic [2:0] F_RECL  = 3'h4;
    localparam logic [TW-1:0] OBJT_RST = 22'h0007D0; // 10 s in 5 ms steps
    localparam logic [TW-1:0] LOCK_RST = 22'h000000;
    localparam logic [5:0]    GEN_RST  = 6'h00;
    localparam logic [1:0]    CTRL_RST = 2'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_INHIBIT, ST_READY, ST_START, ST_OPEN, ST_DEAD,
        ST_CLOSE, ST_ACTION, ST_RECLAIM, ST_LOCKDLY, ST_LOCKED
    } ars_state_e;

    typedef struct packed {
        logic [NCH-1:0] start;
        logic [NCH-1:0] trip;
    } ars_req_s;

    typedef struct packed {
        logic [NOBJ-1:0] isOpen;
        logic [NOBJ-1:0] isClosed;
    } ars_obj_s;

    typedef struct packed {
        ars_req_s req;
        ars_obj_s obj;
        logic     closeAny;
        logic     manClose;
        logic     manReset;
        logic     onOff;
        logic     grp;
    } ars_pin_s;

    typedef struct packed {
        logic       objRun;
        logic       discr;
        logic [2:0] chan;
        logic [2:0] shot;
        ars_state_e state;
    } ars_stat_s;

endpackage : ars_pkg

// [core/ars_sequencer.sv]
// auto-reclose sequencer: settings store, timers and breaker sequencing
//
// Implementation choices: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// (RL1) drive one of five objects, first default
// (RL2) per-group enable, default off, gates action
// (RL3) locked exits on manual reset or close
// (RL4) success starts shot or also general reclaim
// (RL5) lock-out timer after success; zero means ready
// (RL6) request during lock-out: open, then locked
// (RL7) object-close reclaim on manual close/success
// (RL8) request during object reclaim locks, no reclose
// (RL9) disabled shots skipped, next enabled executed
// (RL10) starting delay before opening breaker
// (RL11) starting delay only for pickup requests
// (RL12) trip request with nonzero delay refused
// (RL13) user keeps later-shot delays at zero
// (RL14) dead time from open, then close
// (RL15) arcing/discrimination keeps breaker closed
// (RL16) request in action time locks after reclaim
// (RL17) zero action time skips action phase
// (RL18) shot reclaim after close, fine steps
// (RL19) request during reclaim goes to next shot
// (RL20) settings follow active group live
// (RL21) master enable, default off
// (RL22) optional external on/off input gates use
// (RL23) down-counting timers on fixed step ticks
// (RL24) state and shot shown as status
module ars_sequencer #(
    parameter int FINE_TICK_CYC = ars_pkg::FINE_CYC
) (
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    input  wire logic [ars_pkg::AW-1:0] busAddr,
    input  wire logic [31:0]           busWrData,
    input  wire logic                  busWr,
    input  wire logic                  busRd,
    output logic [31:0]                busRdData,
    input  wire ars_pkg::ars_req_s     reqIn,
    input  wire ars_pkg::ars_obj_s     objIn,
    input  wire logic                  closeAnyIn,
    input  wire logic                  manualCloseIn,
    input  wire logic                  manualResetIn,
    input  wire logic                  onOffIn,
    input  wire logic                  groupIn,
    output logic [ars_pkg::NOBJ-1:0]   openCmd,
    output logic [ars_pkg::NOBJ-1:0]   closeCmd,
    output ars_pkg::ars_stat_s         status,
    output logic [ars_pkg::TW-1:0]     timerLeft
);
    import ars_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    ars_pin_s        pinRaw;
    ars_pin_s        sync1_reg;
    ars_pin_s        pin_reg;
    ars_pin_s        prev_reg;
    logic [1:0]      ctrl_reg;
    logic [5:0]      gen_reg  [NGRP];
    logic [TW-1:0]   lockT_reg [NGRP];
    logic [TW-1:0]   objT_reg [NGRP];
    logic [TW-1:0]   shotMem_reg [1 << MEM_AW];
    logic [31:0]     rdData_reg;
    logic [31:0]     rdNext;
    ars_state_e      state_reg;
    logic [2:0]      chan_reg;
    logic [2:0]      shot_reg;
    logic [TW-1:0]   tmr_reg;
    logic [TW-1:0]   objTmr_reg;
    logic            lockAfter_reg;
    logic            lockOpen_reg;
    logic [NOBJ-1:0] openCmd_reg;
    logic [NOBJ-1:0] closeCmd_reg;
    ars_stat_s       status_reg;
    logic [TW-1:0]   timer_reg;
    logic [31:0]     fineCnt_reg;
    logic [7:0]      coarseCnt_reg;
    logic            fineTick_reg;
    logic            coarseTick_reg;

    // ------------------------------------------------------------
    // derived signals
    // ------------------------------------------------------------
    logic            grp;
    logic [5:0]      gen;
    logic [2:0]      objSel;
    logic [NOBJ-1:0] objHot;
    logic            active;
    logic [NCH-1:0]  reqAct;
    logic [NCH-1:0]  reqNew;
    logic            anyNew;
    logic [2:0]      newCh;
    logic [2:0]      entCh;
    logic [2:0]      entFrom;
    logic [2:0]      entShot;
    logic            entOk;
    logic [TW-1:0]   entDly;
    ars_state_e      entNext;
    logic            tmrTick;
    logic            tmrZero;
    logic            objRun;
    logic            success;

    function automatic logic [MEM_AW-1:0] idx(input logic g, input logic [2:0] c,
                                              input logic [2:0] s, input logic [2:0] f);
        return {g, c, s, f};
    endfunction : idx

    assign pinRaw = '{req: reqIn, obj: objIn, closeAny: closeAnyIn,
                      manClose: manualCloseIn, manReset: manualResetIn,
                      onOff: onOffIn, grp: groupIn};

    assign grp    = pin_reg.grp;                                      // see (RL20)
    assign gen    = gen_reg[grp];
    assign objSel = (gen[GEN_OBJ_LO +: 3] < 3'(NOBJ)) ? gen[GEN_OBJ_LO +: 3] : 3'h0; // see (RL1)
    assign objHot = NOBJ'(1) << objSel;
    assign active = ctrl_reg[CTRL_MASTER] & gen[GEN_EN]               // see (RL2) see (RL21)
                  & (~ctrl_reg[CTRL_USE_ONOFF] | pin_reg.onOff);      // see (RL22)
    assign reqAct = pin_reg.req.start | pin_reg.req.trip;
    assign reqNew = reqAct & ~(prev_reg.req.start | prev_reg.req.trip);
    assign anyNew = |reqNew;
    assign tmrTick = (state_reg == ST_RECLAIM) ? fineTick_reg : coarseTick_reg; // see (RL18)
    assign tmrZero = (tmr_reg == '0);                                 // see (RL23)
    assign objRun  = (objTmr_reg != '0);
    assign success = (state_reg == ST_RECLAIM) && tmrZero && !lockAfter_reg;

    // ------------------------------------------------------------
    // shot selection on a new request
    // ------------------------------------------------------------
    always_comb begin
        newCh = 3'h0;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (reqNew[c]) begin
                newCh = 3'(c);
            end
        end
        entCh   = (state_reg == ST_RECLAIM) ? chan_reg : newCh;
        entFrom = (state_reg == ST_RECLAIM) ? 3'(shot_reg + 3'h1) : 3'h0; // see (RL19)
        entOk   = 1'b0;
        entShot = 3'h0;
        for (int s = NSHOT - 1; s >= 0; s--) begin
            if (3'(s) >= entFrom && shotMem_reg[idx(grp, entCh, 3'(s), F_CFG)][SC_EN]) begin
                entOk   = 1'b1;                                       // see (RL9)
                entShot = 3'(s);
            end
        end
        entDly = shotMem_reg[idx(grp, entCh, entShot, F_START)];
        if (!entOk) begin
            entNext = ST_LOCKED;
        end else if (pin_reg.req.start[entCh]) begin
            entNext = ST_START;                                       // see (RL10) see (RL11)
        end else if (entDly != '0) begin
            entNext = ST_READY;                                       // see (RL12)
        end else begin
            entNext = ST_OPEN;
        end
    end

    // ------------------------------------------------------------
    // input synchroniser and edge history
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= '0;
            pin_reg   <= '0;
            prev_reg  <= '0;
        end else begin
            sync1_reg <= pinRaw;
            pin_reg   <= sync1_reg;
            prev_reg  <= pin_reg;
        end
    end

    // ------------------------------------------------------------
    // step ticks: 0.5 ms fine, 5 ms coarse
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fineCnt_reg    <= '0;
            coarseCnt_reg  <= '0;
            fineTick_reg   <= 1'b0;
            coarseTick_reg <= 1'b0;
        end else begin
            fineTick_reg   <= 1'b0;
            coarseTick_reg <= 1'b0;
            if (fineCnt_reg == 32'(FINE_TICK_CYC - 1)) begin
                fineCnt_reg  <= '0;
                fineTick_reg <= 1'b1;
                if (coarseCnt_reg == 8'(FINE_PER_COARSE - 1)) begin
                    coarseCnt_reg  <= '0;
                    coarseTick_reg <= 1'b1;
                end else begin
                    coarseCnt_reg <= coarseCnt_reg + 8'h01;
                end
            end else begin
                fineCnt_reg <= fineCnt_reg + 32'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RST;
            for (int g = 0; g < NGRP; g++) begin
                gen_reg[g]   <= GEN_RST;
                lockT_reg[g] <= LOCK_RST;                             // see (RL5)
                objT_reg[g]  <= OBJT_RST;                             // see (RL7)
            end
        end else if (busWr) begin
            if (busAddr == A_CTRL) begin
                ctrl_reg <= busWrData[1:0];
            end
            for (int g = 0; g < NGRP; g++) begin
                if (busAddr == A_GEN0 + AW'(g) * GRP_STEP) begin
                    gen_reg[g] <= busWrData[5:0];
                end
                if (busAddr == A_LOCK0 + AW'(g) * GRP_STEP) begin
                    lockT_reg[g] <= busWrData[TW-1:0];
                end
                if (busAddr == A_OBJT0 + AW'(g) * GRP_STEP) begin
                    objT_reg[g] <= busWrData[TW-1:0];
                end
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < (1 << MEM_AW); i++) begin
                shotMem_reg[i] <= '0;
            end
        end else if (busWr && busAddr[SHOT_SEL_BIT]) begin
            shotMem_reg[busAddr[MEM_AW+1:2]] <= busWrData[TW-1:0];
        end
    end

    // ------------------------------------------------------------
    // register reads, data one cycle after the strobe
    // ------------------------------------------------------------
    always_comb begin
        rdNext = '0;
        if (busAddr[SHOT_SEL_BIT]) begin
            rdNext = 32'(shotMem_reg[busAddr[MEM_AW+1:2]]);
        end else if (busAddr == A_CTRL) begin
            rdNext = 32'(ctrl_reg);
        end else if (busAddr == A_STAT) begin
            rdNext = 32'(status_reg);                                 // see (RL24)
        end
        for (int g = 0; g < NGRP; g++) begin
            if (busAddr == A_GEN0 + AW'(g) * GRP_STEP) begin
                rdNext = 32'(gen_reg[g]);
            end
            if (busAddr == A_LOCK0 + AW'(g) * GRP_STEP) begin
                rdNext = 32'(lockT_reg[g]);
            end
            if (busAddr == A_OBJT0 + AW'(g) * GRP_STEP) begin
                rdNext = 32'(objT_reg[g]);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdData_reg <= '0;
        end else begin
            rdData_reg <= busRd ? rdNext : '0;
        end
    end

    // ------------------------------------------------------------
    // object-close reclaim timer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            objTmr_reg <= '0;
        end else if ((pin_reg.manClose && !prev_reg.manClose)
                     || (success && gen[GEN_GEN_RECL])) begin
            objTmr_reg <= objT_reg[grp];                              // see (RL4) see (RL7)
        end else if (coarseTick_reg && objRun) begin
            objTmr_reg <= objTmr_reg - TW'(1);                        // see (RL23)
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg     <= ST_INHIBIT;
            chan_reg      <= 3'h0;
            shot_reg      <= 3'h0;
            tmr_reg       <= '0;
            lockAfter_reg <= 1'b0;
            lockOpen_reg  <= 1'b0;
        end else begin
            if (tmrTick && !tmrZero) begin
                tmr_reg <= tmr_reg - TW'(1);                          // see (RL23)
            end
            if (!active && state_reg != ST_LOCKED) begin
                state_reg <= ST_INHIBIT;
            end else begin
                unique case (state_reg)
                    ST_INHIBIT: begin
                        state_reg <= ST_READY;
                    end
                    ST_READY: begin
                        if (anyNew) begin
                            if (objRun) begin
                                state_reg <= ST_LOCKED;               // see (RL8)
                            end else begin
                                state_reg     <= entNext;
                                chan_reg      <= entCh;
                                shot_reg      <= entShot;
                                tmr_reg       <= entDly;
                                lockAfter_reg <= 1'b0;
                            end
                        end
                    end
                    ST_START: begin
                        if (!reqAct[chan_reg]) begin
                            state_reg <= ST_READY;                    // see (RL10)
                        end else if (tmrZero) begin
                            state_reg <= ST_OPEN;
                        end
                    end
                    ST_OPEN: begin
                        if (pin_reg.obj.isOpen[objSel]) begin
                            state_reg <= ST_DEAD;                     // see (RL14)
                            tmr_reg   <= shotMem_reg[idx(grp, chan_reg, shot_reg, F_DEAD)];
                        end
                    end
                    ST_DEAD: begin
                        if (tmrZero) begin
                            state_reg <= ST_CLOSE;                    // see (RL14)
                        end
                    end
                    ST_CLOSE: begin
                        if (pin_reg.obj.isClosed[objSel]) begin
                            if (shotMem_reg[idx(grp, chan_reg, shot_reg, F_ACT)] != '0) begin
                                state_reg <= ST_ACTION;               // see (RL15)
                                tmr_reg   <= shotMem_reg[idx(grp, chan_reg, shot_reg, F_ACT)];
                            end else begin
                                state_reg <= ST_RECLAIM;              // see (RL17)
                                tmr_reg   <= shotMem_reg[idx(grp, chan_reg, shot_reg, F_RECL)];
                            end
                        end
                    end
                    ST_ACTION: begin
                        if (anyNew) begin
                            lockAfter_reg <= 1'b1;                    // see (RL16)
                        end
                        if (tmrZero) begin
                            state_reg <= ST_RECLAIM;                  // see (RL18)
                            tmr_reg   <= shotMem_reg[idx(grp, chan_reg, shot_reg, F_RECL)];
                        end
                    end
                    ST_RECLAIM: begin
                        if (tmrZero) begin
                            if (lockAfter_reg) begin
                                state_reg <= ST_LOCKED;               // see (RL16)
                            end else if (lockT_reg[grp] != '0) begin
                                state_reg <= ST_LOCKDLY;              // see (RL5)
                                tmr_reg   <= lockT_reg[grp];
                            end else begin
                                state_reg <= ST_READY;                // see (RL5)
                            end
                        end else if (anyNew && !lockAfter_reg) begin
                            state_reg <= entNext;                     // see (RL19)
                            shot_reg  <= entShot;
                            tmr_reg   <= entDly;
                        end
                    end
                    ST_LOCKDLY: begin
                        if (anyNew) begin
                            state_reg    <= ST_LOCKED;                // see (RL6)
                            lockOpen_reg <= 1'b1;
                        end else if (tmrZero) begin
                            state_reg <= ST_READY;
                        end
                    end
                    ST_LOCKED: begin
                        if (pin_reg.obj.isOpen[objSel]) begin
                            lockOpen_reg <= 1'b0;
                        end
                        if ((pin_reg.manReset && !prev_reg.manReset)
                            || (gen[GEN_CLOSE_RST] && pin_reg.closeAny && !prev_reg.closeAny)) begin
                            state_reg    <= ST_READY;                 // see (RL3)
                            lockOpen_reg <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // breaker commands and status
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            openCmd_reg  <= '0;
            closeCmd_reg <= '0;
        end else begin
            openCmd_reg  <= (state_reg == ST_OPEN || lockOpen_reg) ? objHot : '0; // see (RL6)
            closeCmd_reg <= (state_reg == ST_CLOSE) ? objHot : '0;             // see (RL14)
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_reg <= '{objRun: 1'b0, discr: 1'b0, chan: 3'h0, shot: 3'h0,
                            state: ST_INHIBIT};
            timer_reg  <= '0;
        end else begin
            status_reg <= '{objRun: objRun,                            // see (RL24)
                            discr: shotMem_reg[idx(grp, chan_reg, shot_reg, F_CFG)][SC_DISCR],
                            chan: chan_reg, shot: shot_reg, state: state_reg};
            timer_reg  <= tmr_reg;
        end
    end

    assign busRdData = rdData_reg;
    assign openCmd   = openCmd_reg;
    assign closeCmd  = closeCmd_reg;
    assign status    = status_reg;
    assign timerLeft = timer_reg;

endmodule : ars_sequencer

`default_nettype wire

// [tb/ars_sva.sv]
// checker on the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module ars_sva (
    input wire logic                   core_clk,
    input wire logic                   rst,
    input wire logic                   busRd,
    input wire logic [31:0]            busRdData,
    input wire logic [ars_pkg::NOBJ-1:0] openCmd,
    input wire logic [ars_pkg::NOBJ-1:0] closeCmd,
    input wire ars_pkg::ars_stat_s     status
);
    import ars_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    rd_slot_a: assert property (busRdData != 0 |-> $past(busRd)) else $error("stray rd");
    open_one_a: assert property ($onehot0(openCmd)) else $error("open many");
    close_one_a: assert property ($onehot0(closeCmd)) else $error("close many");
    cmd_excl_a: assert property ((openCmd & closeCmd) == 0) else $error("open and close");
    ready_idle_a: assert property (status.state == ST_READY |-> closeCmd == 0) else $error("rdy cl");
    close_phase_a: assert property ($rose(|closeCmd) |-> ##[0:2] status.state inside
        {ST_CLOSE, ST_ACTION, ST_RECLAIM}) else $error("close phase");
    shot_rng_a: assert property (status.shot < NSHOT) else $error("shot range");
    state_rng_a: assert property (status.state <= ST_LOCKED) else $error("state range");
endmodule : ars_sva
bind ars_sequencer ars_sva u_ars_sva (.core_clk(core_clk), .rst(rst), .busRd(busRd),
    .busRdData(busRdData), .openCmd(openCmd), .closeCmd(closeCmd), .status(status));
`default_nettype wire

// [tb/ars_breaker.sv]
// breaker objects answering commands
`timescale 1ns/1ps
`default_nettype none
module ars_breaker (
    input wire logic                   core_clk,
    input wire logic                   rst,
    input wire logic                   slow,
    input wire logic [ars_pkg::NOBJ-1:0] openCmd,
    input wire logic [ars_pkg::NOBJ-1:0] closeCmd,
    output var ars_pkg::ars_obj_s      objIn
);
    import ars_pkg::*;
    logic [NOBJ-1:0] closedReg;
    logic [3:0]      lagReg;
    assign objIn = '{isOpen: ~closedReg, isClosed: closedReg};
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            closedReg <= '1;
            lagReg <= 4'h0;
        end else if ((openCmd | closeCmd) == 0) lagReg <= 4'h0;
        else if (lagReg < (slow ? 4'hA : 4'h1)) lagReg <= lagReg + 4'h1;
        else closedReg <= (closedReg & ~openCmd) | closeCmd;
    end
endmodule : ars_breaker
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ars_pkg::*;
    logic [AW-1:0]   busAddr;
    logic [31:0]     busWrData, busRdData;
    logic            core_clk, rst, busWr, busRd, manualCloseIn, manualResetIn, slow;
    ars_req_s        reqIn;
    ars_obj_s        objIn;
    ars_stat_s       status;
    logic [NOBJ-1:0] openCmd, closeCmd;
    logic [TW-1:0]   timerLeft;
    int              failures, comparisons;
    ars_sequencer #(.FINE_TICK_CYC(4)) u_ars_sequencer (.core_clk(core_clk), .rst(rst),
        .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr), .busRd(busRd),
        .busRdData(busRdData), .reqIn(reqIn), .objIn(objIn), .closeAnyIn(1'b0),
        .manualCloseIn(manualCloseIn), .manualResetIn(manualResetIn), .onOffIn(1'b0),
        .groupIn(1'b0), .openCmd(openCmd), .closeCmd(closeCmd), .status(status),
        .timerLeft(timerLeft));
    ars_breaker u_ars_breaker (.core_clk(core_clk), .rst(rst), .slow(slow),
        .openCmd(openCmd), .closeCmd(closeCmd), .objIn(objIn));
    task close_out;
        if (failures == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : close_out
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [AW-1:0] a, input logic [31:0] d);
        @(posedge core_clk) {busAddr, busWrData, busWr} <= {a, d, 1'b1};
        @(posedge core_clk) busWr <= 1'b0;
    endtask : wr
    task rd(input logic [AW-1:0] a, input logic [31:0] e);
        @(posedge core_clk) {busAddr, busRd} <= {a, 1'b1};
        @(posedge core_clk) busRd <= 1'b0;
        #1 chk("rd", busRdData, e);
    endtask : rd
    // 0 open, 1 close, 2 ready
    task wt(input int c, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            if (c == 0 ? openCmd[0] : c == 1 ? closeCmd[0] : status.state == ST_READY) begin
                @(posedge core_clk);
                return;
            end
        end
        failures++;
        close_out();
    endtask : wt
    function automatic logic [AW-1:0] sw(input logic [2:0] s, input logic [2:0] f);
        return {2'h2, 3'h0, s, f, 2'h0};
    endfunction : sw
    task regs;
        rd(A_CTRL, 32'h0);
        rd(A_GEN0, 32'h0);
        rd(A_LOCK0, 32'h0);
        rd(A_OBJT0, 32'h7D0);
        rd(A_STAT, 32'h0);
        wr(A_CTRL, 32'h1);
        repeat (5) @(posedge core_clk);
        chk("inh", 32'(status.state), 32'(ST_INHIBIT));
        wr(A_GEN0, 32'h1);
        wr(sw(1, F_CFG), 32'h1);
        wr(sw(1, F_DEAD), 32'h3);
        wt(2, 10);
    endtask : regs
    task reclose;
        {slow, reqIn.trip[0]} <= 2'h3;
        wt(0, 20);
        chk("shot", 32'(status.shot), 32'h1);
        repeat (60) @(posedge core_clk);
        chk("cl", 32'(closeCmd), 32'h0);
        chk("dead", 32'(status.state), 32'(ST_DEAD));
        chk("tmr", 32'(timerLeft inside {1, 2}), 32'h1);
        wt(1, 200);
        reqIn.trip[0] <= 1'b0;
        wt(2, 300);
        chk("rdy", 32'(status.state), 32'(ST_READY));
    endtask : reclose
    task refuse;
        wr(sw(1, F_START), 32'h1);
        @(posedge core_clk) reqIn.trip[0] <= 1'b1;
        repeat (100) @(posedge core_clk);
        chk("ref", 32'(status.state), 32'(ST_READY));
        chk("op", 32'(openCmd), 32'h0);
        reqIn.trip[0] <= 1'b0;
        wr(sw(1, F_START), 32'h0);
    endtask : refuse
    task lockout;
        manualCloseIn <= 1'b1;
        repeat (5) @(posedge core_clk) reqIn.trip[0] <= 1'b1;
        repeat (10) @(posedge core_clk);
        chk("lock", 32'(status.state), 32'(ST_LOCKED));
        chk("op", 32'(openCmd), 32'h0);
        manualResetIn <= 1'b1;
        wt(2, 20);
        chk("rst", 32'(status.state), 32'(ST_READY));
    endtask : lockout
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        {rst, busAddr, busWrData, busWr, busRd, reqIn} = {1'b1, 47'h0, 10'h0};
        {manualCloseIn, manualResetIn, slow, failures, comparisons} = '0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        regs();
        reclose();
        refuse();
        lockout();
        close_out();
    end
endmodule : tb_top
`default_nettype wire
